// ===== core/sgtmr_pkg.sv
/*
 * register map, field positions, reset values and types of the timer.
 * assumes an avalon-mm slave with byte addresses, one aligned word per
 * register, 16-bit data in the low bits.
 */
// Operation
// - up mode counts from zero by one, wraps after reload value, flags overflow
// - overflow or underflow gives update event loading buffered reload and prescaler
// - update-disable bit suppresses update events and their transfers
// - down mode counts from reload value to zero, reloads, flags underflow
// - center mode counts zero up to reload value and back, repeating
// - center mode overflow at reload minus one going up, underflow at one down
// - count-direction field in first control register picks the counting mode
// - sixteen-bit prescaler divides counter clock by one to 65536
// - prescaler setting is buffered, takes effect at update event
// - without slave mode the prescaler runs straight from the internal clock
// - counter, reload value and prescaler are sixteen-bit registers
// - capture input passes edge detector, filter and event-count prescaler
// - selected capture edge latches the counter into the compare register
// - capture sets channel flag; interrupt raised when the channel interrupt enable is one
// - eight output compare modes selected by the mode field
// - on compare match output goes high, low or toggles per mode and polarity
// - channel flag raises interrupt if enabled, dma request if selected
// - pwm pulse width from compare value, period from reload value
// - pwm mode 1 active while counter below compare value
// - pwm mode 2 inactive while counter below compare value
// - mode 100 forces reference inactive, 101 forces it active
// - forced modes still raise channel interrupt and dma requests
// - reload writes act at once without preload, else at next update
package sgtmr_pkg;
	// ***********************************************
	// register offsets (byte addresses)
	// ***********************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DIEN = 8'h0c;
	localparam logic [7:0] OFS_STS = 8'h10;
	localparam logic [7:0] OFS_CEG = 8'h14;
	localparam logic [7:0] OFS_CCM = 8'h18;
	localparam logic [7:0] OFS_CCEN = 8'h20;
	localparam logic [7:0] OFS_CNT = 8'h24;
	localparam logic [7:0] OFS_PSC = 8'h28;
	localparam logic [7:0] OFS_ARR = 8'h2c;
	localparam logic [7:0] OFS_CC = 8'h34;
	// field positions
	localparam int CTRL_RUN = 0;
	localparam int CTRL_UD = 1;
	localparam int CTRL_DIR = 4;
	localparam int CTRL_ARPE = 7;
	localparam int DIEN_UIE = 0;
	localparam int DIEN_CCIE = 1;
	localparam int DIEN_DMA = 8;
	localparam int STS_UIF = 0;
	localparam int STS_CCIF = 1;
	localparam int CEG_UG = 0;
	localparam int CCM_SEL = 0;
	localparam int CCM_ICP = 2;
	localparam int CCM_OCM = 4;
	localparam int CCM_FLT = 8;
	localparam int CCEN_EN = 0;
	localparam int CCEN_POL = 1;
	// reset values
	localparam logic [15:0] RST_REG16 = 16'h0000;
	localparam logic [1:0] SEL_OUT = 2'h0;
	localparam logic [1:0] SEL_IN = 2'h1;
	// ***********************************************
	// types
	// ***********************************************
	typedef enum logic [1:0] {
		DIR_UP = 2'h0,
		DIR_DOWN = 2'h1,
		DIR_CTR = 2'h3
	} sgtmr_dir_type;
	typedef enum logic [2:0] {
		OCM_FREEZE = 3'h0,
		OCM_ACT = 3'h1,
		OCM_INACT = 3'h2,
		OCM_TOG = 3'h3,
		OCM_FLO = 3'h4,
		OCM_FHI = 3'h5,
		OCM_PWM1 = 3'h6,
		OCM_PWM2 = 3'h7
	} sgtmr_ocm_type;
	typedef enum logic {
		BUS_IDLE = 1'h0,
		BUS_ACK = 1'h1
	} sgtmr_bus_type;
	typedef struct packed {
		logic arpe;
		sgtmr_dir_type dir;
		logic ud;
		logic run;
	} sgtmr_ctrl_type;
	typedef struct packed {
		logic [3:0] flt;
		logic rsv;
		sgtmr_ocm_type ocm;
		logic [1:0] icp;
		logic [1:0] sel;
	} sgtmr_ccm_type;
endpackage

// ===== core/sgtmr_top.sv
/*
 * single channel 16-bit general timer: time base, capture, compare, pwm.
 * assumes one clock, an avalon-mm master that holds its request until
 * waitrequest is low, and an asynchronous capture pin.
 */
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sgtmr_top #(
	parameter int CNT_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic cap_pin_i,
	output logic ch_out_o,
	output logic irq_o,
	output logic dma_req_o
);
	// ***********************************************
	// elaboration check
	// ***********************************************
	if (CNT_W != 16) begin : g_chk
		$error("sgtmr_top supports only a 16-bit counter");
	end

	sgtmr_pkg::sgtmr_bus_type bus_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [15:0] rd_mux;
	logic wr_go;
	logic [15:0] wd;
	sgtmr_pkg::sgtmr_ctrl_type ctrl_ff;
	sgtmr_pkg::sgtmr_ccm_type ccm_ff;
	logic [15:0] dien_ff;
	logic [1:0] sts_ff;
	logic [1:0] ccen_ff;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [15:0] psc_buf_ff, psc_act_ff, psc_cnt_ff;
	logic [15:0] arr_buf_ff, arr_act_ff, arr_eff;
	logic [15:0] cc_ff;
	logic up_ff, nxt_up;
	logic ovf, unf, ueg_go, uev, tick, tick_d_ff, cnt_wr;
	logic s1_ff, s2_ff, s3_ff, flt_ff, edge_ff;
	logic [3:0] flt_cnt_ff;
	logic [2:0] icp_cnt_ff, icp_lim;
	logic out_mode, in_mode, match, cap_go, ch_set;
	logic oc_ref_ff, ch_out_ff, irq_ff, dma_ff;

	assign wd = avs_writedata_i[15:0];
	assign wr_go = ce_i && avs_write_i && bus_ff == sgtmr_pkg::BUS_ACK;

	// ***********************************************
	// avalon slave: one wait state per access
	// ***********************************************
	// read data is sampled when the request is seen and held for the ack cycle
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus_ff <= sgtmr_pkg::BUS_IDLE;
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else if (ce_i) begin
			case (bus_ff)
				sgtmr_pkg::BUS_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						bus_ff <= sgtmr_pkg::BUS_ACK;
						wait_ff <= 1'b0;
						rdata_ff <= {16'h0000, rd_mux};
					end
				end
				default: begin
					bus_ff <= sgtmr_pkg::BUS_IDLE;
					wait_ff <= 1'b1;
				end
			endcase
		end
	end

	// read decode; unmapped offsets answer zero
	always_comb begin
		rd_mux = 16'h0000;
		if (avs_address_i == sgtmr_pkg::OFS_CTRL) begin
			rd_mux[sgtmr_pkg::CTRL_RUN] = ctrl_ff.run;
			rd_mux[sgtmr_pkg::CTRL_UD] = ctrl_ff.ud;
			rd_mux[sgtmr_pkg::CTRL_DIR +: 2] = ctrl_ff.dir;
			rd_mux[sgtmr_pkg::CTRL_ARPE] = ctrl_ff.arpe;
		end else if (avs_address_i == sgtmr_pkg::OFS_DIEN) begin
			rd_mux = dien_ff;
		end else if (avs_address_i == sgtmr_pkg::OFS_STS) begin
			rd_mux[1:0] = sts_ff;
		end else if (avs_address_i == sgtmr_pkg::OFS_CCM) begin
			rd_mux[11:0] = ccm_ff;
		end else if (avs_address_i == sgtmr_pkg::OFS_CCEN) begin
			rd_mux[1:0] = ccen_ff;
		end else if (avs_address_i == sgtmr_pkg::OFS_CNT) begin
			rd_mux = cnt_ff;
		end else if (avs_address_i == sgtmr_pkg::OFS_PSC) begin
			rd_mux = psc_buf_ff;
		end else if (avs_address_i == sgtmr_pkg::OFS_ARR) begin
			rd_mux = arr_buf_ff;
		end else if (avs_address_i == sgtmr_pkg::OFS_CC) begin
			rd_mux = cc_ff;
		end
	end

	// ***********************************************
	// control registers
	// ***********************************************
	// direction, run and preload bits live in the first control word
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_ff <= '0;
			dien_ff <= sgtmr_pkg::RST_REG16;
			ccm_ff <= '0;
			ccen_ff <= 2'h0;
		end else if (wr_go) begin
			if (avs_address_i == sgtmr_pkg::OFS_CTRL) begin
				ctrl_ff.run <= wd[sgtmr_pkg::CTRL_RUN];
				ctrl_ff.ud <= wd[sgtmr_pkg::CTRL_UD];
				ctrl_ff.dir <= sgtmr_pkg::sgtmr_dir_type'(wd[sgtmr_pkg::CTRL_DIR +: 2]);
				ctrl_ff.arpe <= wd[sgtmr_pkg::CTRL_ARPE];
			end else if (avs_address_i == sgtmr_pkg::OFS_DIEN) begin
				dien_ff <= {7'h00, wd[sgtmr_pkg::DIEN_DMA], 6'h00, wd[1:0]};
			end else if (avs_address_i == sgtmr_pkg::OFS_CCM) begin
				ccm_ff <= {wd[11:8], 1'b0, wd[6:0]}; // bit 7 stays reserved and reads zero
			end else if (avs_address_i == sgtmr_pkg::OFS_CCEN) begin
				ccen_ff <= wd[1:0];
			end
		end
	end

	// prescaler and reload buffers, active copies loaded on update
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			psc_buf_ff <= sgtmr_pkg::RST_REG16;
			psc_act_ff <= sgtmr_pkg::RST_REG16;
			arr_buf_ff <= sgtmr_pkg::RST_REG16;
			arr_act_ff <= sgtmr_pkg::RST_REG16;
		end else if (ce_i) begin
			if (wr_go && avs_address_i == sgtmr_pkg::OFS_PSC) begin
				psc_buf_ff <= wd;
			end
			if (wr_go && avs_address_i == sgtmr_pkg::OFS_ARR) begin
				arr_buf_ff <= wd;
			end
			if (uev) begin
				psc_act_ff <= psc_buf_ff;
				arr_act_ff <= arr_buf_ff;
			end
		end
	end

	// without preload the buffer itself steers the counter
	assign arr_eff = ctrl_ff.arpe ? arr_act_ff : arr_buf_ff;

	// ***********************************************
	// time base
	// ***********************************************
	assign cnt_wr = wr_go && avs_address_i == sgtmr_pkg::OFS_CNT;
	assign ueg_go = wr_go && avs_address_i == sgtmr_pkg::OFS_CEG && wd[sgtmr_pkg::CEG_UG];
	// the internal clock, gated by ce_i, feeds the prescaler directly
	assign tick = ce_i && ctrl_ff.run && psc_cnt_ff == psc_act_ff;
	assign uev = ce_i && (ovf || unf || ueg_go) && !ctrl_ff.ud;

	// prescaler counter: ratio is psc_act plus one
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			psc_cnt_ff <= sgtmr_pkg::RST_REG16;
		end else if (ce_i) begin
			if (ueg_go || tick) begin
				psc_cnt_ff <= 16'h0000;
			end else if (ctrl_ff.run) begin
				psc_cnt_ff <= psc_cnt_ff + 16'h0001;
			end
		end
	end

	// next counter value and overflow/underflow per counting mode
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_up = up_ff;
		ovf = 1'b0;
		unf = 1'b0;
		if (cnt_wr) begin
			nxt_cnt = wd;
		end else if (ueg_go) begin
			nxt_cnt = (ctrl_ff.dir == sgtmr_pkg::DIR_DOWN) ? arr_eff : 16'h0000;
			nxt_up = 1'b1;
		end else if (tick) begin
			case (ctrl_ff.dir)
				sgtmr_pkg::DIR_DOWN: begin
					if (cnt_ff == 16'h0000) begin
						nxt_cnt = arr_eff;
						unf = 1'b1;
					end else begin
						nxt_cnt = cnt_ff - 16'h0001;
					end
				end
				sgtmr_pkg::DIR_CTR: begin
					if (up_ff) begin
						ovf = arr_eff != 16'h0000 && cnt_ff == arr_eff - 16'h0001;
						if (cnt_ff >= arr_eff) begin
							nxt_up = 1'b0;
							nxt_cnt = (cnt_ff == 16'h0000) ? cnt_ff : cnt_ff - 16'h0001;
						end else begin
							nxt_cnt = cnt_ff + 16'h0001;
							nxt_up = (nxt_cnt != arr_eff);
						end
					end else begin
						unf = cnt_ff == 16'h0001;
						if (cnt_ff <= 16'h0001) begin
							nxt_up = 1'b1;
						end
						if (cnt_ff != 16'h0000) begin
							nxt_cnt = cnt_ff - 16'h0001;
						end
					end
				end
				default: begin
					if (cnt_ff >= arr_eff) begin
						nxt_cnt = 16'h0000;
						ovf = 1'b1;
					end else begin
						nxt_cnt = cnt_ff + 16'h0001;
					end
				end
			endcase
		end
	end

	// 16-bit counter and one-bit center-mode direction state
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= sgtmr_pkg::RST_REG16;
			up_ff <= 1'b1;
			tick_d_ff <= 1'b0;
		end else if (ce_i) begin
			cnt_ff <= nxt_cnt;
			up_ff <= nxt_up;
			tick_d_ff <= tick;
		end
	end

	// ***********************************************
	// capture input path
	// ***********************************************
	// three-stage synchroniser; only stages two and three are compared
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else if (ce_i) begin
			s1_ff <= cap_pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// filter: a change must stay for flt extra samples before it is taken
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flt_ff <= 1'b0;
			flt_cnt_ff <= 4'h0;
			edge_ff <= 1'b0;
		end else if (ce_i) begin
			edge_ff <= 1'b0;
			if (s2_ff == s3_ff && s3_ff != flt_ff) begin
				if (flt_cnt_ff >= ccm_ff.flt) begin
					flt_ff <= s3_ff;
					flt_cnt_ff <= 4'h0;
					edge_ff <= s3_ff != ccen_ff[sgtmr_pkg::CCEN_POL];
				end else begin
					flt_cnt_ff <= flt_cnt_ff + 4'h1;
				end
			end else begin
				flt_cnt_ff <= 4'h0;
			end
		end
	end

	// event prescaler: capture on every 1, 2, 4 or 8 edges
	assign in_mode = ccm_ff.sel == sgtmr_pkg::SEL_IN;
	assign out_mode = ccm_ff.sel == sgtmr_pkg::SEL_OUT;
	assign icp_lim = 3'((4'h1 << ccm_ff.icp) - 4'h1);
	assign cap_go = ce_i && edge_ff && in_mode && ccen_ff[sgtmr_pkg::CCEN_EN]
		&& icp_cnt_ff == icp_lim;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			icp_cnt_ff <= 3'h0;
		end else if (ce_i) begin
			if (!in_mode || !ccen_ff[sgtmr_pkg::CCEN_EN]) begin
				icp_cnt_ff <= 3'h0;
			end else if (edge_ff) begin
				icp_cnt_ff <= cap_go ? 3'h0 : icp_cnt_ff + 3'h1;
			end
		end
	end

	// compare register: software writes it, a capture overwrites it
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cc_ff <= sgtmr_pkg::RST_REG16;
		end else if (ce_i) begin
			if (cap_go) begin
				cc_ff <= cnt_ff;
			end else if (wr_go && avs_address_i == sgtmr_pkg::OFS_CC) begin
				cc_ff <= wd;
			end
		end
	end

	// ***********************************************
	// output compare
	// ***********************************************
	// a match is seen once, in the cycle after the counter stepped
	assign match = ce_i && tick_d_ff && out_mode && cnt_ff == cc_ff;
	assign ch_set = match || cap_go;

	// reference level; pwm compares continuously so width follows cc, period arr
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oc_ref_ff <= 1'b0;
		end else if (ce_i && out_mode) begin
			case (ccm_ff.ocm)
				sgtmr_pkg::OCM_ACT: begin
					if (match) oc_ref_ff <= 1'b1;
				end
				sgtmr_pkg::OCM_INACT: begin
					if (match) oc_ref_ff <= 1'b0;
				end
				sgtmr_pkg::OCM_TOG: begin
					if (match) oc_ref_ff <= !oc_ref_ff;
				end
				sgtmr_pkg::OCM_FLO: oc_ref_ff <= 1'b0;
				sgtmr_pkg::OCM_FHI: oc_ref_ff <= 1'b1;
				sgtmr_pkg::OCM_PWM1: oc_ref_ff <= cnt_ff < cc_ff;
				sgtmr_pkg::OCM_PWM2: oc_ref_ff <= !(cnt_ff < cc_ff);
				default: oc_ref_ff <= oc_ref_ff;
			endcase
		end
	end

	// ***********************************************
	// flags, interrupt, dma, pin
	// ***********************************************
	// flags clear on a written zero; a same-cycle event wins over the clear
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sts_ff <= 2'h0;
		end else if (ce_i) begin
			if (wr_go && avs_address_i == sgtmr_pkg::OFS_STS) begin
				sts_ff <= (sts_ff & wd[1:0]) | {ch_set, uev};
			end else begin
				sts_ff <= sts_ff | {ch_set, uev};
			end
		end
	end

	// pin polarity flips the reference; a disabled channel drives low
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ch_out_ff <= 1'b0;
			irq_ff <= 1'b0;
			dma_ff <= 1'b0;
		end else if (ce_i) begin
			ch_out_ff <= out_mode && ccen_ff[sgtmr_pkg::CCEN_EN]
				&& (oc_ref_ff ^ ccen_ff[sgtmr_pkg::CCEN_POL]);
			irq_ff <= |(sts_ff & dien_ff[1:0]);
			dma_ff <= ch_set && dien_ff[sgtmr_pkg::DIEN_DMA];
		end
	end

	assign avs_readdata_o = rdata_ff;
	assign avs_waitrequest_o = wait_ff;
	assign ch_out_o = ch_out_ff;
	assign irq_o = irq_ff;
	assign dma_req_o = dma_ff;

	// ***********************************************
	// assertions
	// ***********************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_up_wrap;
		tick && !cnt_wr && !ueg_go && ctrl_ff.dir == sgtmr_pkg::DIR_UP && cnt_ff == arr_eff;
	endsequence
	property p_up_wrap;
		s_up_wrap |-> ovf ##1 cnt_ff == 16'h0000;
	endproperty
	a_up_wrap: assert property (p_up_wrap) else $error("up wrap failed");
	property p_uev_load;
		uev |=> psc_act_ff == $past(psc_buf_ff) && arr_act_ff == $past(arr_buf_ff);
	endproperty
	a_uev_load: assert property (p_uev_load) else $error("update did not load");
	property p_ud_block;
		ctrl_ff.ud && !uev |=> $stable(psc_act_ff);
	endproperty
	a_ud_block: assert property (p_ud_block) else $error("update while disabled");
	property p_down_reload;
		tick && !cnt_wr && !ueg_go && ctrl_ff.dir == sgtmr_pkg::DIR_DOWN && cnt_ff == 16'h0000
			|=> cnt_ff == $past(arr_eff);
	endproperty
	a_down_reload: assert property (p_down_reload) else $error("down reload wrong");
	property p_ctr_ovf;
		tick && !cnt_wr && !ueg_go && ctrl_ff.dir == sgtmr_pkg::DIR_CTR && up_ff
			&& arr_eff > 16'h0001 && cnt_ff == arr_eff - 16'h0001 |-> ovf ##1 cnt_ff == $past(arr_eff);
	endproperty
	a_ctr_ovf: assert property (p_ctr_ovf) else $error("center overflow wrong");
	property p_capture;
		cap_go |=> cc_ff == $past(cnt_ff) && sts_ff[sgtmr_pkg::STS_CCIF];
	endproperty
	a_capture: assert property (p_capture) else $error("capture lost");
	property p_irq;
		ce_i && ch_set && dien_ff[sgtmr_pkg::DIEN_CCIE] ##1 ce_i |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("channel irq missing");
	property p_dma;
		ch_set && dien_ff[sgtmr_pkg::DIEN_DMA] |=> dma_req_o;
	endproperty
	a_dma: assert property (p_dma) else $error("dma request missing");
	property p_force;
		ce_i && out_mode && ccm_ff.ocm == sgtmr_pkg::OCM_FLO |=> !oc_ref_ff;
	endproperty
	a_force: assert property (p_force) else $error("forced low not held");
	property p_pwm1;
		ce_i && out_mode && ccm_ff.ocm == sgtmr_pkg::OCM_PWM1 |=> oc_ref_ff == ($past(cnt_ff) < $past(cc_ff));
	endproperty
	a_pwm1: assert property (p_pwm1) else $error("pwm1 level wrong");
	property p_hold;
		ce_i && !ctrl_ff.run && !cnt_wr && !ueg_go |=> cnt_ff == $past(cnt_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while stopped");
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
/*
 * self-checking bench for the single channel timer: registers, pwm duty, capture.
 * assumes the avalon slave answers in time; a hang is left to the watchdog.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
	typedef struct {string name; logic [31:0] exp;} sgtmr_note_type;
	logic ref_clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0, avs_write_i = 1'b0, cap_pin_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
	logic avs_waitrequest_o, ch_out_o, irq_o, dma_req_o;
	sgtmr_note_type notes[$];
	int error_cnt = 0, n_compared = 0, meas_left = 0, highs = 0, dma_cnt = 0;
	sgtmr_top uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .cap_pin_i(cap_pin_i), .ch_out_o(ch_out_o),
		.irq_o(irq_o), .dma_req_o(dma_req_o));
	initial begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	// ***********************************************
	// result watcher: pops the oldest note per result
	// ***********************************************
	task automatic judge(input logic [31:0] got);
		sgtmr_note_type n;
		if (notes.size() == 0) begin
			error_cnt++;
			$display("CHECK FAILED unexpected result expected none seen %h", got);
		end else begin
			n = notes.pop_front();
			`CHK(n.name, n.exp, got)
		end
	endtask
	// read acks and duty windows both count as results; sampled pre-edge values
	always @(posedge ref_clk_i) begin
		if (dma_req_o === 1'b1) dma_cnt++;
		if (avs_read_i && avs_waitrequest_o === 1'b0) judge(avs_readdata_o);
		if (meas_left > 0) begin
			highs += (ch_out_o === 1'b1) ? 1 : 0;
			meas_left--;
			if (meas_left == 0) judge(32'(highs));
		end
	end
	// ***********************************************
	// bus master and helpers
	// ***********************************************
	// one extra edge after release keeps two requests from sharing a time step
	task automatic bus(input logic [7:0] a, input logic wr, input logic [15:0] d);
		avs_address_i <= a;
		avs_writedata_i <= {16'($urandom), d}; // upper half must be ignored
		avs_write_i <= wr;
		avs_read_i <= !wr;
		// no cycle count is assumed: only the watchdog may end this wait
		do begin
			@(posedge ref_clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
		notes.push_back('{nm, {16'h0, e}});
		bus(a, 1'b0, 16'h0);
	endtask
	// duty window of two periods; expectation noted before counting starts
	task automatic meas(input int per, input int tot);
		int n;
		notes.push_back('{"duty", 32'(tot)});
		highs = 0;
		meas_left = 2 * per;
		for (n = 0; n < 4 * per + 100 && meas_left > 0; n++) @(posedge ref_clk_i);
	endtask
	task automatic pwm_case(input logic [1:0] dir, input logic [2:0] ocm, input logic pol,
		input int prescale_divider, input int arr, input int cc);
		int per, act;
		per = (dir == 2'h3) ? 2 * arr : arr + 1;
		if (ocm == 3'h4) act = 0;
		else if (ocm == 3'h5) act = per;
		else if (ocm == 3'h3) act = per / 2;
		else begin
			act = (cc > arr) ? per : (cc == 0) ? 0 : (dir == 2'h3) ? 2 * cc - 1 : cc;
			if (ocm == 3'h7) act = per - act;
		end
		if (pol) act = per - act;
		wr(sgtmr_pkg::OFS_CTRL, 16'h0000);
		wr(sgtmr_pkg::OFS_PSC, 16'(prescale_divider));
		wr(sgtmr_pkg::OFS_ARR, 16'(arr));
		wr(sgtmr_pkg::OFS_CC, 16'(cc));
		wr(sgtmr_pkg::OFS_CCM, 16'({ocm, 4'h0}));
		wr(sgtmr_pkg::OFS_CCEN, 16'({pol, 1'b1}));
		wr(sgtmr_pkg::OFS_CEG, 16'h0001); // load prescaler now
		wr(sgtmr_pkg::OFS_CTRL, 16'({dir, 4'h1}));
		repeat (2 * per * (prescale_divider + 1) + 8) @(posedge ref_clk_i);
		if (ocm == 3'h3) meas(per * (prescale_divider + 1), per * (prescale_divider + 1));
		else meas(per * (prescale_divider + 1), 2 * act * (prescale_divider + 1));
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ***********************************************
	// watchdog and main sequence
	// ***********************************************
	initial begin
		#100000;
		error_cnt++;
		$display("CHECK FAILED watchdog expected done seen hang");
		tally_and_finish();
	end
	initial begin
		logic [7:0] offs[10];
		logic [1:0] dirs[3];
		logic [15:0] v;
		int arr;
		offs = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h04};
		dirs = '{2'h0, 2'h1, 2'h3};
		void'($urandom(32'hea17));
		repeat (16) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		@(posedge ref_clk_i);
		// reset values, unmapped address included
		foreach (offs[i]) rd(offs[i], 16'h0000, "reset value");
		wr(sgtmr_pkg::OFS_PSC, 16'hffff);
		rd(sgtmr_pkg::OFS_PSC, 16'hffff, "psc width");
		$display("test registers done");
		// every direction against the forced and pwm modes (4 to 7), random shape
		foreach (dirs[d]) for (int m = 4; m < 8; m++) begin
			arr = 3 + $urandom % 10;
			pwm_case(dirs[d], 3'(m), 1'($urandom), $urandom % 3, arr,
				$urandom % (arr + 3));
		end
		pwm_case(2'h0, 3'h6, 1'b0, 0, 7, 0);
		pwm_case(2'h3, 3'h6, 1'b0, 1, 7, 8);
		pwm_case(2'h0, 3'h3, 1'b0, 0, 9, 4);
		$display("test waveforms done");
		// update disable holds the buffered prescaler and the update flag
		pwm_case(2'h0, 3'h6, 1'b0, 0, 3, 2);
		wr(sgtmr_pkg::OFS_CTRL, 16'h0003);
		wr(sgtmr_pkg::OFS_STS, 16'h0000);
		wr(sgtmr_pkg::OFS_PSC, 16'h0001);
		meas(4, 4);
		rd(sgtmr_pkg::OFS_STS, 16'h0002, "flags no update");
		wr(sgtmr_pkg::OFS_CTRL, 16'h0001);
		repeat (20) @(posedge ref_clk_i);
		meas(8, 8);
		rd(sgtmr_pkg::OFS_STS, 16'h0003, "flags update");
		pwm_case(2'h0, 3'h5, 1'b0, 0, 5, 2);
		wr(sgtmr_pkg::OFS_STS, 16'h0000);
		repeat (20) @(posedge ref_clk_i);
		rd(sgtmr_pkg::OFS_STS, 16'h0003, "forced match flag");
		// clock enable low freezes the running counter: one step before, none seen after
		wr(sgtmr_pkg::OFS_ARR, 16'hffff);
		wr(sgtmr_pkg::OFS_CNT, 16'h0000);
		ce_i <= 1'b0;
		repeat (10) @(posedge ref_clk_i);
		ce_i <= 1'b1;
		rd(sgtmr_pkg::OFS_CNT, 16'h0001, "frozen count");
		$display("test update done");
		// capture on a stopped counter: value must hold and be latched
		v = 16'($urandom);
		wr(sgtmr_pkg::OFS_CTRL, 16'h0000);
		wr(sgtmr_pkg::OFS_CNT, v);
		wr(sgtmr_pkg::OFS_CCM, 16'h0001);
		wr(sgtmr_pkg::OFS_CCEN, 16'h0001);
		wr(sgtmr_pkg::OFS_DIEN, 16'h0103);
		wr(sgtmr_pkg::OFS_STS, 16'h0000);
		dma_cnt = 0;
		cap_pin_i <= 1'b1;
		repeat (30) @(posedge ref_clk_i);
		rd(sgtmr_pkg::OFS_CNT, v, "held count");
		rd(sgtmr_pkg::OFS_CC, v, "captured count");
		rd(sgtmr_pkg::OFS_STS, 16'h0002, "capture flag");
		`CHK("irq", 1'b1, irq_o)
		`CHK("dma pulses", 1, dma_cnt)
		wr(sgtmr_pkg::OFS_STS, 16'h0000);
		repeat (4) @(posedge ref_clk_i);
		`CHK("irq cleared", 1'b0, irq_o)
		wr(sgtmr_pkg::OFS_CNT, ~v);
		cap_pin_i <= 1'b0;
		repeat (30) @(posedge ref_clk_i);
		rd(sgtmr_pkg::OFS_CC, v, "falling edge ignored");
		$display("test capture done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
